// ===== dv/spi_master_model.sv
// Purpose: Serial bus master that sends one 16-bit frame and collects the reply.
// Assumes: Serial clock idles low; the device shifts on falling edges.
// Notes: Phases are longer than the two-clock input synchroniser delay.
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
   // Clock.
   input wire logic clock,
   // Serial pins.
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   task automatic xfer(input logic [1:0] cmd, output logic [15:0] rx);
      logic [15:0] tx;
      tx = {cmd, 14'h1a5};
      @(posedge clock);
      cs_n <= 1'b0;
      mosi <= tx[15];
      repeat (6) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
         rx[i] = miso;
         sclk <= 1'b1;
         repeat (5) @(posedge clock);
         sclk <= 1'b0;
         if (i > 0) begin
            mosi <= tx[i-1];
         end
         repeat (6) @(posedge clock);
      end
      // A deselected data line shows no stale value.
      cs_n <= 1'b1;
      mosi <= ~mosi;
      repeat (6) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the status response word.
// Assumes: Status bytes settle two clocks after a set or read pulse.
// Notes: Tables give the group and extended bits per source index.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import status_word_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic sclk, cs_n, mosi, miso;
   src_vec_t int_set, wake_set, rst_set, cond_active, flag_read;
   logic [7:0] fixed_status, ext_status;
   int fail_count = 0;
   int compares = 0;
   localparam logic [7:0] GRP [8] = '{8'h10, 8'h10, 8'h08, 8'h04, 8'h04, 8'h02, 8'h01, 8'h01};
   localparam logic [7:0] EXT [8] = '{8'h40, 8'h80, 8'h10, 8'h04, 8'h08, 8'h00, 8'h01, 8'h02};

   always #5 clock = ~clock;

   status_word u_status_word (.clock(clock), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso(miso), .int_set(int_set), .wake_set(wake_set), .rst_set(rst_set), .cond_active(cond_active),
      .flag_read(flag_read), .fixed_status(fixed_status), .ext_status(ext_status));
   spi_master_model u_spi_master_model (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Kind 0..2 raises an interrupt, wake or reset flag; kind 3 reads it back.
   task automatic pulse(input int kind, input logic [7:0] v);
      @(posedge clock);
      case (kind)
         0: int_set <= src_vec_t'(v);
         1: wake_set <= src_vec_t'(v);
         2: rst_set <= src_vec_t'(v);
         default: flag_read <= src_vec_t'(v);
      endcase
      @(posedge clock);
      int_set <= '0;
      wake_set <= '0;
      rst_set <= '0;
      flag_read <= '0;
      repeat (3) @(posedge clock);
   endtask

   task automatic test_sources();
      logic [15:0] rx, exp;
      for (int k = 0; k < 3; k++) begin
         for (int s = 0; s < 8; s++) begin
            exp = {(8'h80 >> k) | GRP[s], EXT[s]};
            pulse(k, 8'h01 << s);
            chk({fixed_status, ext_status}, exp);
            u_spi_master_model.xfer(CMD_WRITE, rx);
            chk(rx, exp);
            pulse(3, 8'h01 << s);
            chk({fixed_status, ext_status}, 16'h0000);
         end
      end
      $display("test sources done");
   endtask

   task automatic test_reads();
      logic [15:0] rx;
      pulse(0, 8'h04);
      u_spi_master_model.xfer(CMD_READ_A, rx);
      chk(rx, 16'h8800);
      u_spi_master_model.xfer(CMD_READ_B, rx);
      chk(rx, 16'h8800);
      @(posedge clock);
      cond_active <= src_vec_t'(8'h04);
      pulse(3, 8'h04);
      chk({fixed_status, ext_status}, 16'h8810);
      cond_active <= '0;
      pulse(3, 8'h04);
      chk({fixed_status, ext_status}, 16'h0000);
      $display("test reads done");
   endtask

   task automatic test_snapshot();
      logic [15:0] rx;
      pulse(1, 8'h20);
      fork
         u_spi_master_model.xfer(CMD_WRITE, rx);
         begin
            repeat (40) @(posedge clock);
            pulse(0, 8'h80);
         end
      join
      chk(rx, 16'h4200);
      chk({fixed_status, ext_status}, 16'hc302);
      pulse(3, 8'ha0);
      chk({fixed_status, ext_status}, 16'h0000);
      $display("test snapshot done");
   endtask

   task automatic conclude();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      int_set = '0;
      wake_set = '0;
      rst_set = '0;
      cond_active = '0;
      flag_read = '0;
      repeat (16) @(posedge clock);
      chk({fixed_status, ext_status}, 16'h0000);
      chk({15'h0000, miso}, 16'h0000);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      $display("test reset done");
      test_sources();
      test_reads();
      test_snapshot();
      conclude();
   end

   // The full run needs under 10000 clocks; this limit leaves ample margin.
   initial begin
      repeat (50000) @(posedge clock);
      fail_count++;
      conclude();
   end
endmodule
`default_nettype wire

// ===== rtl/status_word.sv
// Purpose: Latches event flags and shifts the fixed and extended status bytes out on the serial output.
// Assumes: Serial pins are sampled by the system clock, which runs well above the serial clock.
// Notes: Source index 7 is the high regulator bank; index 6 the low bank.
// Operation
// - Read commands 00 or 11 return only the one-byte fixed status.
// - Write command 01 returns fixed status followed by the extended byte.
// - Interrupt summary bit is set while interrupt flags are pending unread.
// - Wake summary bit is set while wake flags are pending unread.
// - Reset summary bit is set while reset source flags are pending unread.
// - CAN group bit is set for pending local or bus CAN sources.
// - LIN event sets both LIN group and LIN channel bits.
// - I/O group bit is set when any I/O pin is the pending source.
// - Safe group bit is set when a safe-state condition is pending.
// - Regulator group bit is set for pending regulator or voltage monitor events.
// - CAN local bit is set only for locally caused CAN events.
// - CAN bus bit is set only for CAN events on the bus wires.
// - I/O-low bit marks a pending flag in the low I/O half.
// - I/O-high bit marks a pending flag in the high I/O half.
// - Regulator high and low bits mark flags in each regulator half.
// - A flag clears when it is read while its underlying condition is inactive.
`timescale 1ns/100ps
`default_nettype none
module status_word
(
   // Clock and reset.
   input wire logic clock,
   input wire logic arst_n,
   // Serial pins from the master.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   // Serial output towards the master.
   output logic miso,
   // Event sources: set pulses, live conditions and read strobes, one bit per source.
   input wire status_word_pkg::src_vec_t int_set,
   input wire status_word_pkg::src_vec_t wake_set,
   input wire status_word_pkg::src_vec_t rst_set,
   input wire status_word_pkg::src_vec_t cond_active,
   input wire status_word_pkg::src_vec_t flag_read,
   // Live status view.
   output logic [7:0] fixed_status,
   output logic [7:0] ext_status
);
   import status_word_pkg::*;

   typedef struct packed {
      logic [1:0] sclk_s;
      logic [1:0] cs_s;
      logic [1:0] mosi_s;
      logic sclk_d;
      frame_t frame;
      logic [3:0] bit_cnt;
      logic [1:0] cmd;
      logic [15:0] shift;
      flags_t flags;
      logic miso;
      logic [7:0] fixed;
      logic [7:0] ext;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   logic [NUM_SRC:0] any_pend;
   logic [7:0] fix_c;
   logic [7:0] ext_c;
   logic rise;
   logic fall;
   logic [NUM_SRC:0] set_any;

   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_s = {st_r.sclk_s[0], sclk};
      st_nxt.cs_s = {st_r.cs_s[0], cs_n};
      st_nxt.mosi_s = {st_r.mosi_s[0], mosi};
      st_nxt.sclk_d = st_r.sclk_s[1];
      rise = st_r.sclk_s[1] & ~st_r.sclk_d;
      fall = ~st_r.sclk_s[1] & st_r.sclk_d;
      // Set wins over a clear arriving in the same cycle.
      st_nxt.flags.int_pend = int_set.src
         | (st_r.flags.int_pend & ~(flag_read.src & ~cond_active.src));
      st_nxt.flags.wake_pend = wake_set.src
         | (st_r.flags.wake_pend & ~(flag_read.src & ~cond_active.src));
      st_nxt.flags.rst_pend = rst_set.src
         | (st_r.flags.rst_pend & ~(flag_read.src & ~cond_active.src));
      any_pend = st_r.flags.int_pend | st_r.flags.wake_pend | st_r.flags.rst_pend;
      fix_c = BYTE_RESET;
      fix_c[FIX_INT_POS] = |st_r.flags.int_pend;
      fix_c[FIX_WAKE_POS] = |st_r.flags.wake_pend;
      fix_c[FIX_RST_POS] = |st_r.flags.rst_pend;
      fix_c[FIX_CAN_POS] = any_pend[SRC_CAN_LOCAL_SOURCE] | any_pend[SRC_CAN_BUS];
      fix_c[FIX_LIN_POS] = any_pend[SRC_LIN];
      fix_c[FIX_IO_POS] = any_pend[SRC_IO_LO] | any_pend[SRC_IO_HI];
      fix_c[FIX_SAFE_POS] = any_pend[SRC_SAFE];
      fix_c[FIX_REG_POS] = any_pend[SRC_REG_LO] | any_pend[NUM_SRC];
      ext_c = BYTE_RESET;
      ext_c[EXT_CAN_BUS_POS] = any_pend[SRC_CAN_BUS];
      ext_c[EXT_CAN_LOCAL_SOURCE_POS] = any_pend[SRC_CAN_LOCAL_SOURCE];
      ext_c[EXT_ZERO_POS] = 1'b0;
      ext_c[EXT_LIN_POS] = any_pend[SRC_LIN];
      ext_c[EXT_IO_HI_POS] = any_pend[SRC_IO_HI];
      ext_c[EXT_IO_LO_POS] = any_pend[SRC_IO_LO];
      ext_c[EXT_REG_HI_POS] = any_pend[NUM_SRC];
      ext_c[EXT_REG_LO_POS] = any_pend[SRC_REG_LO];
      st_nxt.fixed = fix_c;
      st_nxt.ext = ext_c;
      unique case (st_r.frame)
         FR_IDLE: begin
            if (!st_r.cs_s[1]) begin
               // The snapshot keeps the word steady even if flags move mid-frame.
               st_nxt.shift = {fix_c, ext_c};
               st_nxt.miso = fix_c[7];
               st_nxt.bit_cnt = 4'h0;
               st_nxt.frame = FR_SHIFT;
            end
         end
         FR_SHIFT: begin
            if (st_r.cs_s[1]) begin
               st_nxt.frame = FR_IDLE;
               st_nxt.miso = 1'b0;
            end else begin
               if (rise) begin
                  if (st_r.bit_cnt == 4'h0) begin
                     st_nxt.cmd[1] = st_r.mosi_s[1];
                  end
                  if (st_r.bit_cnt == 4'h1) begin
                     st_nxt.cmd[0] = st_r.mosi_s[1];
                  end
               end
               if (fall) begin
                  st_nxt.shift = {st_r.shift[14:0], 1'b0};
                  if (st_r.bit_cnt != BIT_CNT_LAST) begin
                     st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                  end
                  // Second byte is the extended status only for writes, zeros otherwise.
                  if (st_r.bit_cnt >= 4'h7 && st_r.cmd != CMD_WRITE) begin
                     st_nxt.miso = 1'b0;
                  end else begin
                     st_nxt.miso = st_r.shift[14];
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '{sclk_s: 2'h0, cs_s: 2'h3, mosi_s: 2'h0, sclk_d: 1'b0, frame: FR_IDLE,
                   bit_cnt: 4'h0, cmd: 2'h0, shift: 16'h0000, flags: '0, miso: 1'b0,
                   fixed: 8'h00, ext: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign miso = st_r.miso;
   assign fixed_status = st_r.fixed;
   assign ext_status = st_r.ext;
   assign set_any = int_set.src | wake_set.src | rst_set.src;

   a_int_summary: assert property (@(posedge clock) disable iff (!arst_n)
      (|int_set.src) |=> ##1 fixed_status[FIX_INT_POS])
      else $error("interrupt summary not raised");
   a_wake_summary: assert property (@(posedge clock) disable iff (!arst_n)
      (|wake_set.src) |=> ##1 fixed_status[FIX_WAKE_POS])
      else $error("wake summary not raised");
   a_rst_summary: assert property (@(posedge clock) disable iff (!arst_n)
      (|rst_set.src) |=> ##1 fixed_status[FIX_RST_POS])
      else $error("reset summary not raised");
   a_can_group: assert property (@(posedge clock) disable iff (!arst_n)
      fixed_status[FIX_CAN_POS] == (ext_status[EXT_CAN_BUS_POS] | ext_status[EXT_CAN_LOCAL_SOURCE_POS]))
      else $error("can group mismatch");
   a_lin_pair: assert property (@(posedge clock) disable iff (!arst_n)
      fixed_status[FIX_LIN_POS] == ext_status[EXT_LIN_POS])
      else $error("lin bits disagree");
   a_io_group: assert property (@(posedge clock) disable iff (!arst_n)
      fixed_status[FIX_IO_POS] == (ext_status[EXT_IO_HI_POS] | ext_status[EXT_IO_LO_POS]))
      else $error("io group mismatch");
   a_reg_group: assert property (@(posedge clock) disable iff (!arst_n)
      fixed_status[FIX_REG_POS] == (ext_status[EXT_REG_HI_POS] | ext_status[EXT_REG_LO_POS]))
      else $error("regulator group mismatch");
   a_ext_zero: assert property (@(posedge clock) disable iff (!arst_n)
      !ext_status[EXT_ZERO_POS])
      else $error("reserved extended bit set");
   a_snap_stable: assert property (@(posedge clock) disable iff (!arst_n)
      (st_r.frame == FR_SHIFT && !fall && !st_r.cs_s[1]) |=> $stable(st_r.shift))
      else $error("snapshot moved mid-frame");
   a_can_local_source_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_CAN_LOCAL_SOURCE] |=> ##1 (fixed_status[FIX_CAN_POS] && ext_status[EXT_CAN_LOCAL_SOURCE_POS]))
      else $error("can local source not reported");
   a_can_bus_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_CAN_BUS] |=> ##1 (fixed_status[FIX_CAN_POS] && ext_status[EXT_CAN_BUS_POS]))
      else $error("can bus source not reported");
   a_lin_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_LIN] |=> ##1 (fixed_status[FIX_LIN_POS] && ext_status[EXT_LIN_POS]))
      else $error("lin source not reported");
   a_io_lo_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_IO_LO] |=> ##1 (fixed_status[FIX_IO_POS] && ext_status[EXT_IO_LO_POS]))
      else $error("low io source not reported");
   a_io_hi_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_IO_HI] |=> ##1 (fixed_status[FIX_IO_POS] && ext_status[EXT_IO_HI_POS]))
      else $error("high io source not reported");
   a_safe_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_SAFE] |=> ##1 fixed_status[FIX_SAFE_POS])
      else $error("safe source not reported");
   a_reg_lo_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[SRC_REG_LO] |=> ##1 (fixed_status[FIX_REG_POS] && ext_status[EXT_REG_LO_POS]))
      else $error("low regulator source not reported");
   a_reg_hi_src: assert property (@(posedge clock) disable iff (!arst_n)
      set_any[NUM_SRC] |=> ##1 (fixed_status[FIX_REG_POS] && ext_status[EXT_REG_HI_POS]))
      else $error("high regulator source not reported");
   a_read_tail: assert property (@(posedge clock) disable iff (!arst_n)
      (st_r.frame == FR_SHIFT && st_r.bit_cnt >= 4'h8 && st_r.cmd != CMD_WRITE) |-> !miso)
      else $error("read frame sent a second byte");
   a_flag_clear: assert property (@(posedge clock) disable iff (!arst_n)
      (any_pend & $past(flag_read.src & ~cond_active.src & ~set_any)) == '0)
      else $error("read flag did not clear");
   a_active_hold: assert property (@(posedge clock) disable iff (!arst_n)
      ($past(any_pend & cond_active.src) & ~any_pend) == '0)
      else $error("flag cleared while condition present");
endmodule
`default_nettype wire

// ===== rtl/status_word_pkg.sv
// Purpose: Shared constants and carriers for the serial status response word.
// Assumes: One clock at 100 MHz; serial framing signals come from pins.
// Notes: Bit positions are within the fixed byte and the extended byte.
package status_word_pkg;
   localparam logic [1:0] CMD_READ_A = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ_B = 2'h3;
   localparam int FIX_INT_POS = 7;
   localparam int FIX_WAKE_POS = 6;
   localparam int FIX_RST_POS = 5;
   localparam int FIX_CAN_POS = 4;
   localparam int FIX_LIN_POS = 3;
   localparam int FIX_IO_POS = 2;
   localparam int FIX_SAFE_POS = 1;
   localparam int FIX_REG_POS = 0;
   localparam int EXT_CAN_BUS_POS = 7;
   localparam int EXT_CAN_LOCAL_SOURCE_POS = 6;
   localparam int EXT_ZERO_POS = 5;
   localparam int EXT_LIN_POS = 4;
   localparam int EXT_IO_HI_POS = 3;
   localparam int EXT_IO_LO_POS = 2;
   localparam int EXT_REG_HI_POS = 1;
   localparam int EXT_REG_LO_POS = 0;
   localparam int NUM_SRC = 7;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] BIT_CNT_LAST = 4'hf;

   // Per-source event lines, one bit per source in the order given by the indices below.
   localparam int SRC_CAN_LOCAL_SOURCE = 0;
   localparam int SRC_CAN_BUS = 1;
   localparam int SRC_LIN = 2;
   localparam int SRC_IO_LO = 3;
   localparam int SRC_IO_HI = 4;
   localparam int SRC_SAFE = 5;
   localparam int SRC_REG_LO = 6;

   typedef struct packed {
      logic [NUM_SRC:0] src;
   } src_vec_t;

   typedef struct packed {
      logic [NUM_SRC:0] int_pend;
      logic [NUM_SRC:0] wake_pend;
      logic [NUM_SRC:0] rst_pend;
   } flags_t;

   typedef enum logic [1:0] {
      FR_IDLE,
      FR_SHIFT
   } frame_t;
endpackage
